// >>> rtl/dfas_pkg.sv
// Purpose: Constants and types of the drive fault and alarm supervisor
// Assumes: Current 0.1 A, voltage 1 V, frequency 0.1 Hz, temp 0.1 degC
// Notes: Overload level is counted in 0.1 % steps
package dfas_pkg;
  // Measurement bundle
  typedef struct packed {
    logic [6:0] cur;
    logic [9:0] dcv;
    logic [11:0] freq;
    logic [10:0] temp;
  } dfas_meas_t;
  // One fault history entry
  typedef struct packed {
    logic [9:0] code;
    dfas_meas_t meas;
  } dfas_hist_t;
  // Auto-reset states
  typedef enum logic [1:0] {
    ARS_RUN = 2'b00,
    ARS_WAIT = 2'b01,
    ARS_LOCK = 2'b11
  } dfas_ars_t;
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int SEC_CYC = CLK_HZ;
  localparam int MS_CYC = CLK_HZ / MS_PER_S;
  // Register offsets
  localparam logic [7:0] RA_CTRL = 8'h00;
  localparam logic [7:0] RA_FTH = 8'h04;
  localparam logic [7:0] RA_FHY = 8'h08;
  localparam logic [7:0] RA_ITH = 8'h0c;
  localparam logic [7:0] RA_RATED = 8'h10;
  localparam logic [7:0] RA_OVL = 8'h14;
  localparam logic [7:0] RA_ARST = 8'h18;
  localparam logic [7:0] RA_STAT = 8'h1c;
  localparam logic [7:0] RA_CODES = 8'h20;
  localparam logic [7:0] RA_LEVEL = 8'h24;
  localparam logic [1:0] RA_HIST_TOP = 2'h1;
  // Control bits
  localparam int CB_RST = 0;
  localparam int CB_EXTA = 1;
  localparam int CB_EXTF = 2;
  localparam int CB_PSRC = 3;
  localparam int CB_SUPHI = 4;
  // Reset values
  localparam logic [11:0] FTH_RST = 12'h01e;
  localparam logic [11:0] FHY_RST = 12'h005;
  localparam logic [6:0] RATED_RST = 7'h10;
  localparam logic [6:0] ITH_RST = RATED_RST;
  localparam logic [7:0] OVL_RST = 8'h13;
  localparam logic [7:0] ARST_RST = 8'h00;
  // Trip levels
  localparam logic [10:0] TEMP_ALM = 11'h44c;
  localparam logic [10:0] TEMP_FLT = 11'h4b0;
  localparam logic [9:0] UV_LO = 10'h0e6;
  localparam logic [9:0] OV_LO = 10'h1cc;
  localparam logic [9:0] UV_HI = 10'h0c8;
  localparam logic [9:0] OV_HI = 10'h19a;
  localparam logic [6:0] HYST_DIV = 7'h14;
  localparam logic [9:0] OVL_ALM = 10'h03f;
  localparam logic [9:0] OVL_FULL = 10'h3e8;
  localparam int TRIP_PCT = 150;
  localparam int TRIP_S = 60;
  localparam int OVL_STEP_MUL = (TRIP_PCT - 100) * TRIP_S / 100;
  localparam logic [7:0] SAVE_MAX = 8'h20;
  localparam logic [4:0] LOCK_WIN_S = 5'h1e;
  localparam logic [1:0] LOCK_CNT = 2'h3;
  // Fault bits and codes
  localparam int FB_UV = 0;
  localparam int FB_OV = 1;
  localparam int FB_OT = 2;
  localparam int FB_OC = 3;
  localparam int FB_OL = 4;
  localparam int FB_SAVE = 5;
  localparam int FB_COPY = 6;
  localparam int FB_EXT = 7;
  localparam int FB_PNL = 8;
  localparam int NF = 9;
  localparam logic [9:0] FC_UV = 10'h015;
  localparam logic [9:0] FC_OV = 10'h016;
  localparam logic [9:0] FC_OT = 10'h033;
  localparam logic [9:0] FC_OC = 10'h046;
  localparam logic [9:0] FC_OL = 10'h048;
  localparam logic [9:0] FC_SAVE = 10'h051;
  localparam logic [9:0] FC_COPY = 10'h052;
  localparam logic [9:0] FC_EXT = 10'h05b;
  localparam logic [9:0] FC_PNL = 10'h2bd;
  // Alarm bits and codes
  localparam int AB_OL = 0;
  localparam int AB_OT = 1;
  localparam int AB_HWID = 2;
  localparam int AB_EXT = 3;
  localparam int AB_PNL = 4;
  localparam int NA = 5;
  localparam logic [9:0] AC_OL = 10'h02e;
  localparam logic [9:0] AC_OT = 10'h032;
  localparam logic [9:0] AC_HWID = 10'h054;
  localparam logic [9:0] AC_EXT = 10'h05a;
  localparam logic [9:0] AC_PNL = 10'h2bc;
endpackage

// >>> rtl/dfas_ovl.sv
// Purpose: Current-time integrator for motor overload
// Assumes: tick_ms is a one-cycle pulse each millisecond
// Notes: One level step is 0.1 % of the trip integral
`timescale 1ns/1ps
module dfas_ovl #(
  parameter int STEP_MUL = dfas_pkg::OVL_STEP_MUL
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Measurement and settings
  input wire logic tick_ms,
  input wire logic [6:0] cur,
  input wire logic [7:0] ovl_lvl,
  input wire logic [6:0] rated,
  // Restore from non-volatile store
  input wire logic nv_load,
  input wire logic [9:0] nv_level,
  // Results
  output logic [9:0] level,
  output logic alarm,
  output logic fault
);
  logic [9:0] lvl_q, lvl_d;
  logic [13:0] sub_q, sub_d;
  // Excess or deficit against the overload level
  wire logic dis = {1'b0, ovl_lvl} >= {1'b0, rated, 1'b0}; // RQ7
  wire logic over = {1'b0, cur} > ovl_lvl;
  wire logic [7:0] diff = over ? 8'({1'b0, cur} - ovl_lvl)
                               : 8'(ovl_lvl - {1'b0, cur});
  wire logic [13:0] step = 14'(ovl_lvl * STEP_MUL); // RQ6
  wire logic full = lvl_q >= dfas_pkg::OVL_FULL;
  wire logic [13:0] refill = step > 14'(diff) ? step - 14'(diff) : 14'h0;

  // Integrate on ticks, turn whole steps into level between ticks
  always_comb begin
    lvl_d = lvl_q;
    sub_d = sub_q;
    if (dis) begin // RQ7
      lvl_d = 10'h000;
      sub_d = 14'h0000;
    end else if (nv_load) begin // RQ5
      lvl_d = nv_level > dfas_pkg::OVL_FULL ? dfas_pkg::OVL_FULL : nv_level;
      sub_d = 14'h0000;
    end else if (tick_ms && over) begin // RQ4
      sub_d = full ? sub_q : sub_q + 14'(diff);
    end else if (tick_ms) begin
      if (sub_q >= 14'(diff)) begin
        sub_d = sub_q - 14'(diff);
      end else if (lvl_q != 10'h000) begin
        lvl_d = lvl_q - 10'h001;
        sub_d = refill;
      end else begin
        sub_d = 14'h0000;
      end
    end else if (over && !full && sub_q >= step) begin // RQ6
      sub_d = sub_q - step;
      lvl_d = lvl_q + 10'h001;
    end
  end

  // State
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lvl_q <= 10'h000;
      sub_q <= 14'h0000;
    end else begin
      lvl_q <= lvl_d;
      sub_q <= sub_d;
    end
  end

  // Level report and thresholds
  assign level = lvl_q;
  assign alarm = lvl_q >= dfas_pkg::OVL_ALM; // RQ8
  assign fault = full; // RQ8

  AST_OL_DIS: assert property (@(posedge sys_clk) disable iff (!resetn)
    dis |=> (level == 10'h000 && !alarm)) // RQ7
    else $error("overload active while disabled");
  AST_OL_NORISE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!over && !nv_load) |=> level <= $past(level)) // RQ6
    else $error("overload level rose below overload current");
  AST_OL_ORDER: assert property (@(posedge sys_clk) disable iff (!resetn)
    fault |-> (alarm && level == 10'h3e8)) // RQ8
    else $error("overload fault without full level");
endmodule

// >>> rtl/dfas_top.sv
// Purpose: Drive fault and alarm supervisor with register port
// Assumes: meas is on sys_clk; pins are asynchronous, oc, panel present and panel link active high, the others active low
// Notes: Reads return data in the cycle after the read strobe
// How it works
// [RQ1] Frequency relay switches at threshold plus/minus hysteresis
// [RQ2] Current relay releases 5 % rated below
// [RQ3] Any fault blocks PWM, motor coasts
// [RQ4] Integrate current above overload level
// [RQ5] Integrator level restored from non-volatile store
// [RQ6] 150 % overload trips in 60 s
// [RQ7] Overload off at twice rated current
// [RQ8] Overload alarm 6.3 %, fault 100 %
// [RQ9] Temperature alarm 110 C, fault 120 C
// [RQ10] Overcurrent cuts PWM, declares fault
// [RQ11] DC link limits follow supply range
// [RQ12] Broken panel link raises panel alarm
// [RQ13] Panel fault only when panel is source
// [RQ14] Failed hardware identification raises alarm
// [RQ15] Save faults above 32 changes or protected
// [RQ16] Copy aborts on version digit mismatch
// [RQ17] External alarm while its input inactive
// [RQ18] External fault input inactive blocks PWM
// [RQ19] Keep three most recent faults with data; only a fault arriving with none latched, or in the clear cycle, is recorded
// [RQ20] Auto-reset after programmed seconds, zero disables
// [RQ21] Three same faults within 30 s lock
// [RQ22] Faults stay latched until reset
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module dfas_top #(
  parameter int SEC_CYC = dfas_pkg::SEC_CYC,
  parameter int MS_CYC = dfas_pkg::MS_CYC,
  parameter logic [7:0] FW_VER_XY = 8'h12 // Arbitrary version digits
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  // Measurements
  input dfas_pkg::dfas_meas_t meas,
  // Asynchronous pins
  input wire logic oc_pin,
  input wire logic ext_alarm_pin,
  input wire logic ext_fault_pin,
  input wire logic panel_present_pin,
  input wire logic panel_link_pin,
  // Parameter services
  input wire logic nv_load,
  input wire logic [9:0] nv_level,
  input wire logic hw_id_done,
  input wire logic hw_id_ok,
  input wire logic save_req,
  input wire logic [7:0] save_diff,
  input wire logic save_wp,
  input wire logic copy_req,
  input wire logic [7:0] copy_ver,
  // Drive side outputs
  output logic pwm_enable,
  output logic relay_freq,
  output logic relay_current,
  output logic [9:0] ovl_level,
  output logic [9:0] fault_code,
  output logic [9:0] alarm_code,
  output logic autoreset_locked
);
  localparam int MSW = $clog2(MS_CYC);
  localparam int SW = $clog2(SEC_CYC);
  localparam int NF = dfas_pkg::NF;

  // Highest numbered fault wins the report
  function automatic logic [9:0] fcode(input logic [NF-1:0] v);
    fcode = 10'h000;
    if (v[dfas_pkg::FB_UV]) fcode = dfas_pkg::FC_UV;
    if (v[dfas_pkg::FB_OV]) fcode = dfas_pkg::FC_OV;
    if (v[dfas_pkg::FB_OT]) fcode = dfas_pkg::FC_OT;
    if (v[dfas_pkg::FB_OC]) fcode = dfas_pkg::FC_OC;
    if (v[dfas_pkg::FB_OL]) fcode = dfas_pkg::FC_OL;
    if (v[dfas_pkg::FB_SAVE]) fcode = dfas_pkg::FC_SAVE;
    if (v[dfas_pkg::FB_COPY]) fcode = dfas_pkg::FC_COPY;
    if (v[dfas_pkg::FB_EXT]) fcode = dfas_pkg::FC_EXT;
    if (v[dfas_pkg::FB_PNL]) fcode = dfas_pkg::FC_PNL;
  endfunction

  // Highest numbered alarm wins the report
  function automatic logic [9:0] acode(input logic [4:0] v);
    acode = 10'h000;
    if (v[dfas_pkg::AB_OL]) acode = dfas_pkg::AC_OL;
    if (v[dfas_pkg::AB_OT]) acode = dfas_pkg::AC_OT;
    if (v[dfas_pkg::AB_HWID]) acode = dfas_pkg::AC_HWID;
    if (v[dfas_pkg::AB_EXT]) acode = dfas_pkg::AC_EXT;
    if (v[dfas_pkg::AB_PNL]) acode = dfas_pkg::AC_PNL;
  endfunction

  // Two-stage pin synchroniser
  logic [4:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
    end else begin
      pin_s1_q <= {panel_link_pin, panel_present_pin, ext_fault_pin,
                   ext_alarm_pin, oc_pin};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire logic oc_s = pin_s2_q[0];
  wire logic exta_s = pin_s2_q[1];
  wire logic extf_s = pin_s2_q[2];
  wire logic pnl_s = pin_s2_q[3];
  wire logic link_s = pin_s2_q[4];

  // Millisecond and second ticks
  logic [MSW-1:0] ms_q;
  logic [SW-1:0] sec_q;
  wire logic tick_ms = ms_q == MSW'(MS_CYC - 1);
  wire logic tick_s = sec_q == SW'(SEC_CYC - 1);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ms_q <= '0;
      sec_q <= '0;
    end else begin
      ms_q <= tick_ms ? '0 : ms_q + MSW'(1);
      sec_q <= tick_s ? '0 : sec_q + SW'(1);
    end
  end

  // Write decode
  wire logic wr_ctrl = bus_wr && bus_addr == dfas_pkg::RA_CTRL;
  wire logic man_clr = wr_ctrl && bus_wdata[dfas_pkg::CB_RST];
  logic [4:1] ctrl_q;
  logic [11:0] fth_q, fhy_q;
  logic [6:0] ith_q, rated_q;
  logic [7:0] ovl_q, arst_q;

  // Settings written by software
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= 4'h0;
      fth_q <= dfas_pkg::FTH_RST;
      fhy_q <= dfas_pkg::FHY_RST;
      ith_q <= dfas_pkg::ITH_RST;
      rated_q <= dfas_pkg::RATED_RST;
      ovl_q <= dfas_pkg::OVL_RST;
      arst_q <= dfas_pkg::ARST_RST;
    end else if (bus_wr) begin
      if (wr_ctrl) ctrl_q <= bus_wdata[4:1];
      if (bus_addr == dfas_pkg::RA_FTH) fth_q <= bus_wdata[11:0];
      if (bus_addr == dfas_pkg::RA_FHY) fhy_q <= bus_wdata[11:0];
      if (bus_addr == dfas_pkg::RA_ITH) ith_q <= bus_wdata[6:0];
      if (bus_addr == dfas_pkg::RA_RATED) rated_q <= bus_wdata[6:0];
      if (bus_addr == dfas_pkg::RA_OVL) ovl_q <= bus_wdata[7:0];
      if (bus_addr == dfas_pkg::RA_ARST) arst_q <= bus_wdata[7:0];
    end
  end
  wire logic exta_en = ctrl_q[dfas_pkg::CB_EXTA];
  wire logic extf_en = ctrl_q[dfas_pkg::CB_EXTF];
  wire logic psrc = ctrl_q[dfas_pkg::CB_PSRC];
  wire logic suphi = ctrl_q[dfas_pkg::CB_SUPHI];

  // Relay switch levels
  wire logic [12:0] f_on = {1'b0, fth_q} + {1'b0, fhy_q}; // RQ1
  wire logic [11:0] f_off = fth_q > fhy_q ? fth_q - fhy_q : 12'h000;
  wire logic [6:0] i_hys = rated_q / dfas_pkg::HYST_DIV; // RQ2
  wire logic [6:0] i_off = ith_q > i_hys ? ith_q - i_hys : 7'h00;
  logic rel_f_q, rel_i_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rel_f_q <= 1'b0;
      rel_i_q <= 1'b0;
    end else begin
      if ({1'b0, meas.freq} >= f_on) rel_f_q <= 1'b1; // RQ1
      else if (meas.freq <= f_off) rel_f_q <= 1'b0; // RQ1
      if (meas.cur > ith_q) rel_i_q <= 1'b1; // RQ2
      else if (meas.cur < i_off) rel_i_q <= 1'b0; // RQ2
    end
  end

  // Overload integrator
  logic ol_alm, ol_flt;
  dfas_ovl u_ovl (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tick_ms(tick_ms),
    .cur(meas.cur),
    .ovl_lvl(ovl_q),
    .rated(rated_q),
    .nv_load(nv_load),
    .nv_level(nv_level),
    .level(ovl_level),
    .alarm(ol_alm),
    .fault(ol_flt)
  );

  // Alarm conditions
  logic hwid_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) hwid_q <= 1'b0;
    else if (hw_id_done) hwid_q <= !hw_id_ok; // RQ14
  end
  wire logic pnl_alm = pnl_s && !link_s; // RQ12
  wire logic [4:0] alm = {pnl_alm, exta_en && !exta_s, hwid_q, // RQ17
    meas.temp >= dfas_pkg::TEMP_ALM, ol_alm}; // RQ9

  // Fault conditions
  wire logic [9:0] uv_lvl = suphi ? dfas_pkg::UV_HI : dfas_pkg::UV_LO;
  wire logic [9:0] ov_lvl = suphi ? dfas_pkg::OV_HI : dfas_pkg::OV_LO;
  wire logic [NF-1:0] fset = {
    pnl_alm && psrc, // RQ13
    extf_en && !extf_s, // RQ18
    copy_req && copy_ver != FW_VER_XY, // RQ16
    save_req && (save_diff > dfas_pkg::SAVE_MAX || save_wp), // RQ15
    ol_flt, // RQ4
    oc_s, // RQ10
    meas.temp >= dfas_pkg::TEMP_FLT, // RQ9
    meas.dcv >= ov_lvl, // RQ11
    meas.dcv <= uv_lvl}; // RQ11

  // Latch: a set in the clear cycle wins
  logic [NF-1:0] flt_q;
  logic auto_clr;
  wire logic clr = man_clr || auto_clr;
  wire logic [NF-1:0] flt_d = (flt_q & ~{NF{clr}}) | fset; // RQ22
  wire logic any_f = |flt_q;
  wire logic new_flt = |fset && (!any_f || clr);
  wire logic [9:0] new_code = fcode(fset);
  logic pwm_q;
  logic [9:0] fcode_q, acode_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flt_q <= '0;
      pwm_q <= 1'b0;
      fcode_q <= 10'h000;
      acode_q <= 10'h000;
    end else begin
      flt_q <= flt_d; // RQ22
      pwm_q <= !(|flt_d); // RQ3 RQ10 RQ18
      fcode_q <= fcode(flt_d);
      acode_q <= acode(alm);
    end
  end

  // Repeat tracking for auto-reset lockout
  dfas_pkg::dfas_ars_t ars_q, ars_d;
  logic [7:0] ars_sec_q;
  logic [4:0] win_q;
  logic win_on_q;
  logic [1:0] rpt_q;
  logic [9:0] last_q;
  wire logic same = win_on_q && new_code == last_q; // RQ21
  wire logic [1:0] rpt_inc = rpt_q == dfas_pkg::LOCK_CNT ? rpt_q
                                                         : rpt_q + 2'h1;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rpt_q <= 2'h0;
      last_q <= 10'h000;
      win_q <= 5'h00;
      win_on_q <= 1'b0;
    end else begin
      if (man_clr) rpt_q <= 2'h0;
      else if (new_flt) rpt_q <= same ? rpt_inc : 2'h1; // RQ21
      if (new_flt) last_q <= new_code;
      if (auto_clr) win_q <= 5'h00;
      else if (tick_s && win_on_q) win_q <= win_q + 5'h01;
      if (auto_clr) win_on_q <= 1'b1;
      else if (win_q == dfas_pkg::LOCK_WIN_S) win_on_q <= 1'b0;
    end
  end

  // Auto-reset sequencer
  assign auto_clr = ars_q == dfas_pkg::ARS_WAIT && any_f
    && ars_sec_q == arst_q; // RQ20
  always_comb begin
    ars_d = ars_q;
    unique case (ars_q)
      dfas_pkg::ARS_RUN: begin
        if (rpt_q == dfas_pkg::LOCK_CNT) ars_d = dfas_pkg::ARS_LOCK;
        else if (any_f && arst_q != 8'h00) ars_d = dfas_pkg::ARS_WAIT;
      end
      dfas_pkg::ARS_WAIT: begin
        if (!any_f || auto_clr) ars_d = dfas_pkg::ARS_RUN; // RQ20
      end
      dfas_pkg::ARS_LOCK: begin
        if (man_clr) ars_d = dfas_pkg::ARS_RUN; // RQ21
      end
      default: ars_d = dfas_pkg::ARS_RUN;
    endcase
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ars_q <= dfas_pkg::ARS_RUN;
      ars_sec_q <= 8'h00;
    end else begin
      ars_q <= ars_d;
      if (ars_q != dfas_pkg::ARS_WAIT || auto_clr) ars_sec_q <= 8'h00;
      else if (tick_s) ars_sec_q <= ars_sec_q + 8'h01;
    end
  end

  // Fault history, newest in entry 0
  dfas_pkg::dfas_hist_t hist_q [3];
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hist_q[0] <= '0;
      hist_q[1] <= '0;
      hist_q[2] <= '0;
    end else if (new_flt) begin
      hist_q[2] <= hist_q[1]; // RQ19
      hist_q[1] <= hist_q[0];
      hist_q[0] <= {new_code, meas}; // RQ19
    end
  end

  // Read selection
  wire logic [1:0] h_idx = bus_addr[4:3];
  wire logic h_hit = bus_addr[7:6] == dfas_pkg::RA_HIST_TOP
    && !bus_addr[5] && h_idx != 2'h3;
  wire dfas_pkg::dfas_hist_t h_sel = hist_q[h_hit ? h_idx : 2'h0];
  wire logic [31:0] h_word = bus_addr[2]
    ? {3'h0, h_sel.meas.cur, h_sel.meas.dcv, h_sel.meas.freq}
    : {11'h000, h_sel.code, h_sel.meas.temp};
  wire logic locked = ars_q == dfas_pkg::ARS_LOCK;
  wire logic [31:0] stat = {2'h0, pwm_q, locked, 2'h0, rel_i_q,
    rel_f_q, 3'h0, alm, 7'h00, flt_q};
  wire logic [31:0] rd_val =
    bus_addr == dfas_pkg::RA_CTRL ? {27'h0, ctrl_q, 1'b0} :
    bus_addr == dfas_pkg::RA_FTH ? {20'h0, fth_q} :
    bus_addr == dfas_pkg::RA_FHY ? {20'h0, fhy_q} :
    bus_addr == dfas_pkg::RA_ITH ? {25'h0, ith_q} :
    bus_addr == dfas_pkg::RA_RATED ? {25'h0, rated_q} :
    bus_addr == dfas_pkg::RA_OVL ? {24'h0, ovl_q} :
    bus_addr == dfas_pkg::RA_ARST ? {24'h0, arst_q} :
    bus_addr == dfas_pkg::RA_STAT ? stat :
    bus_addr == dfas_pkg::RA_CODES ? {6'h0, acode_q, 6'h0, fcode_q} :
    bus_addr == dfas_pkg::RA_LEVEL ? {22'h0, ovl_level} :
    h_hit ? h_word : 32'h0;
  logic [31:0] rdata_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) rdata_q <= 32'h0;
    else rdata_q <= bus_rd ? rd_val : 32'h0;
  end

  // Outputs
  assign bus_rdata = rdata_q;
  assign pwm_enable = pwm_q;
  assign relay_freq = rel_f_q;
  assign relay_current = rel_i_q;
  assign fault_code = fcode_q;
  assign alarm_code = acode_q;
  assign autoreset_locked = locked;

  // Checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_PWM_BLOCK: assert property (any_f |-> !pwm_enable) // RQ3
    else $error("pwm enabled with fault latched");
  AST_OC_CUT: assert property (oc_s |=> flt_q[3] && !pwm_enable) // RQ10
    else $error("overcurrent did not cut pwm");
  AST_OT_TRIP: assert property (meas.temp >= 11'h4b0 |=> flt_q[2]) // RQ9
    else $error("overtemperature fault missing");
  AST_UV_LO: assert property (!suphi && meas.dcv <= 10'h0e6 // RQ11
    |=> fault_code != 10'h000)
    else $error("undervoltage not reported");
  AST_EXT_FLT: assert property (extf_en && !extf_s // RQ18
    |=> ##0 !pwm_enable)
    else $error("external fault left pwm on");
  AST_PNL_FLT: assert property (pnl_alm && !psrc && !flt_q[8] // RQ13
    |=> !flt_q[8])
    else $error("panel fault without panel as source");
  AST_LATCH: assert property (any_f && !clr |=> any_f) // RQ22
    else $error("fault dropped without reset");
  AST_FREQ_ON: assert property ({1'b0, meas.freq} >= f_on // RQ1
    |=> relay_freq)
    else $error("frequency relay did not close");
  AST_SAVE_FLT: assert property (save_req && save_wp // RQ15
    |=> flt_q[5] && fault_code >= 10'h051)
    else $error("protected save not faulted");
  AST_ARST_OFF: assert property (arst_q == 8'h00 |-> !auto_clr) // RQ20
    else $error("auto reset while disabled");
  AST_LOCK_HOLD: assert property (locked && !man_clr // RQ21
    |=> locked && !auto_clr)
    else $error("lockout left without manual reset");
  COV_OC: cover property (oc_s ##1 !pwm_enable);
  COV_AUTO: cover property (auto_clr ##1 !any_f);
  COV_LOCK: cover property (!locked ##1 locked);
endmodule

// >>> dv/dfas_plant.sv
// Purpose: Far-side model of power stage, gate logic and sensors
// Assumes: Setpoints come from the bench
// Notes: Current and frequency drop to 0 while gating is blocked
`timescale 1ns/1ps
module dfas_plant (
  // Clock
  input wire logic sys_clk,
  // Setpoints
  input wire logic [6:0] i_set,
  input wire logic [11:0] f_set,
  input wire logic [9:0] v_set,
  input wire logic [10:0] t_set,
  // Gating and measurements
  input wire logic pwm_enable,
  output dfas_pkg::dfas_meas_t meas
);
  // Blocked gating lets the motor coast with no current
  always_ff @(posedge sys_clk) begin
    meas.cur <= pwm_enable ? i_set : 7'h00;
    meas.freq <= pwm_enable ? f_set : 12'h000;
    meas.dcv <= v_set;
    meas.temp <= t_set;
  end
endmodule

// >>> dv/test_drive_fault_alarm_supervisor.sv
// Purpose: Self-checking bench of the fault and alarm supervisor
// Assumes: Second and millisecond counts shortened to 100 and 20 cycles
// Notes: Plant model feeds measurements back from gating
`timescale 1ns/1ps
module test_drive_fault_alarm_supervisor;
  logic sys_clk = 1'b0, resetn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  logic oc_pin = 1'b0, ext_alarm_pin = 1'b1, ext_fault_pin = 1'b1;
  logic panel_present_pin = 1'b0, panel_link_pin = 1'b1, hw_id_ok = 1'b0;
  logic save_wp = 1'b0, pwm_enable, relay_freq, relay_current, rf = 1'b0;
  logic autoreset_locked;
  logic [3:0] req = 4'h0;
  logic [7:0] bus_addr = 8'h00, save_diff = 8'h00, copy_ver = 8'h12;
  logic [9:0] nv_level = 10'h000, v_set = 10'h12c;
  logic [9:0] ovl_level, fault_code, alarm_code;
  logic [6:0] i_set = 7'h00;
  logic [11:0] f_set = 12'h000;
  logic [10:0] t_set = 11'h0fa;
  logic [31:0] bus_wdata = 32'h0, bus_rdata, rv, ctrl = 32'h0;
  logic [31:0] lf = 32'h000185f9;
  logic [7:0] ra [7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h3c};
  logic [31:0] re [7] = '{32'h1e, 32'h5, 32'h10, 32'h10, 32'h13, 32'h0, 32'h0};
  dfas_pkg::dfas_meas_t meas;
  int failures = 0, num_checks = 0, cyc = 0;
  // Clock and instances
  always #5 sys_clk = ~sys_clk;
  dfas_top #(.SEC_CYC(100), .MS_CYC(20)) dut (.*, .save_req(req[0]),
    .copy_req(req[1]), .hw_id_done(req[2]), .nv_load(req[3]));
  dfas_plant plant (.*);
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 rv = bus_rdata;
  endtask
  // One-cycle service request
  task automatic pl(input int k);
    @(posedge sys_clk);
    req[k] <= 1'b1;
    @(posedge sys_clk);
    req <= 4'h0;
  endtask
  task automatic fc(input string s, input logic [9:0] f, input logic p);
    tk(5);
    chk(s, {22'h0, f}, {22'h0, fault_code});
    chk(s, {31'h0, p}, {31'h0, pwm_enable});
  endtask
  task automatic clr();
    wr(dfas_pkg::RA_CTRL, ctrl | 32'h1);
  endtask
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Relay with on level 3.5 Hz and off level 2.5 Hz
  function automatic logic fexp(input logic p, input logic [11:0] f);
    return (f >= 12'h023) ? 1'b1 : ((f <= 12'h019) ? 1'b0 : p);
  endfunction
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    tk(8);
    resetn <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reg", re[i], rv);
    end
    repeat (14) begin
      lf = nx(lf);
      f_set <= 12'h010 + {7'h0, lf[3:0], 1'b0};
      tk(4);
      rf = fexp(rf, f_set);
      chk("relay_freq", {31'h0, rf}, {31'h0, relay_freq});
    end
    i_set <= 7'h14;
    tk(4);
    chk("relay_cur", 32'h1, {31'h0, relay_current});
    i_set <= 7'h05;
    nv_level <= 10'h046;
    pl(3);
    tk(4);
    chk("ovl_lvl", 32'h1, {31'h0, ovl_level inside {[60:70]}});
    chk("relay_cur", 32'h0, {31'h0, relay_current});
    chk("ovl_alm", dfas_pkg::AC_OL, {22'h0, alarm_code});
    nv_level <= 10'h3e8;
    pl(3);
    fc("ovl_flt", dfas_pkg::FC_OL, 1'b0);
    nv_level <= 10'h000;
    pl(3);
    clr();
    fc("ovl_clr", 10'h000, 1'b1);
    wr(dfas_pkg::RA_OVL, 32'h20);
    nv_level <= 10'h1f4;
    pl(3);
    tk(4);
    chk("ovl_off", 32'h0, {22'h0, ovl_level});
    wr(dfas_pkg::RA_OVL, 32'h13);
    t_set <= 11'h456;
    tk(5);
    chk("ot_alm", dfas_pkg::AC_OT, {22'h0, alarm_code});
    t_set <= 11'h4ba;
    fc("ot_flt", dfas_pkg::FC_OT, 1'b0);
    t_set <= 11'h0fa;
    fc("ot_hold", dfas_pkg::FC_OT, 1'b0);
    clr();
    fc("ot_clr", 10'h000, 1'b1);
    for (int s = 0; s < 2; s++) begin
      ctrl[dfas_pkg::CB_SUPHI] = s[0];
      wr(dfas_pkg::RA_CTRL, ctrl);
      v_set <= s[0] ? 10'h0c8 : 10'h0e6;
      fc("uv", dfas_pkg::FC_UV, 1'b0);
      v_set <= s[0] ? 10'h19a : 10'h1cc;
      fc("ov", dfas_pkg::FC_OV, 1'b0);
      v_set <= 10'h12c;
      clr();
      fc("v_clr", 10'h000, 1'b1);
    end
    i_set <= 7'h0c;
    f_set <= 12'h028;
    oc_pin <= 1'b1;
    fc("oc", dfas_pkg::FC_OC, 1'b0);
    oc_pin <= 1'b0;
    rd(8'h40);
    chk("hist0", dfas_pkg::FC_OC, {22'h0, rv[20:11]});
    rd(8'h44);
    chk("hist0m", {3'h0, 7'h0c, 10'h12c, 12'h028}, rv);
    rd(8'h48);
    chk("hist1", dfas_pkg::FC_UV, {22'h0, rv[20:11]});
    clr();
    ctrl[dfas_pkg::CB_EXTA] = 1'b1;
    wr(dfas_pkg::RA_CTRL, ctrl);
    ext_alarm_pin <= 1'b0;
    fc("ext_alm", 10'h000, 1'b1);
    chk("ext_alm", dfas_pkg::AC_EXT, {22'h0, alarm_code});
    ext_alarm_pin <= 1'b1;
    tk(5);
    chk("ext_alm_off", 32'h0, {22'h0, alarm_code});
    ctrl[dfas_pkg::CB_EXTF] = 1'b1;
    wr(dfas_pkg::RA_CTRL, ctrl);
    ext_fault_pin <= 1'b0;
    fc("ext_flt", dfas_pkg::FC_EXT, 1'b0);
    ext_fault_pin <= 1'b1;
    panel_present_pin <= 1'b1;
    panel_link_pin <= 1'b0;
    // Pins need the synchroniser delay, else set beats clear
    tk(2);
    clr();
    fc("pnl", 10'h000, 1'b1);
    chk("pnl_alm", dfas_pkg::AC_PNL, {22'h0, alarm_code});
    ctrl[dfas_pkg::CB_PSRC] = 1'b1;
    wr(dfas_pkg::RA_CTRL, ctrl);
    fc("pnl_flt", dfas_pkg::FC_PNL, 1'b0);
    panel_link_pin <= 1'b1;
    tk(2);
    clr();
    save_diff <= 8'h20;
    pl(0);
    fc("save32", 10'h000, 1'b1);
    save_wp <= 1'b1;
    pl(0);
    fc("save_wp", dfas_pkg::FC_SAVE, 1'b0);
    save_wp <= 1'b0;
    clr();
    copy_ver <= 8'h22;
    pl(1);
    fc("copy", dfas_pkg::FC_COPY, 1'b0);
    clr();
    pl(2);
    tk(3);
    chk("hwid", dfas_pkg::AC_HWID, {22'h0, alarm_code});
    wr(dfas_pkg::RA_ARST, 32'h2);
    save_diff <= 8'h21;
    for (int i = 0; i < 3; i++) begin
      pl(0);
      fc("ar_set", dfas_pkg::FC_SAVE, 1'b0);
      tk(250);
      chk("ar", (i == 2) ? dfas_pkg::FC_SAVE : 10'h0, {22'h0, fault_code});
    end
    chk("lock", 32'h1, {31'h0, autoreset_locked});
    clr();
    fc("unlock", 10'h000, 1'b1);
    finish_test();
  end
endmodule
